// File: hw/afc_flow_ctrl.sv
// Contract
// (R1) No pause or jam while transmitter disabled
// (R2) High threshold in 64-byte units triggers
// (R3) Full duplex: one pause frame at high
// (R4) Half duplex: jam matching frames for duration
// (R5) Below low threshold: send zero-time pause
// (R6) Zero pause only after pause, when enabled
// (R7) Software keeps low below high
// (R8) Duration field ignored in full duplex
// (R9) Duration table, 10M adds 2.2 us
// (R10) Multicast criterion jams in half duplex
// (R11) Broadcast criterion jams in half duplex
// (R12) Own-address criterion jams in half duplex
// (R13) Any-frame bit enables both duplex modes
// (R14) Any-frame half duplex reacts at preamble
// (R15) Any-frame full duplex requests pause immediately
// (R16) Any-frame overrides other criteria
// (R17) No criteria set means no action
`include "afc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module afc_flow_ctrl #(
  parameter int unsigned JAM_UNIT_CYC = `AFC_JAM_UNIT_NS / `AFC_CLK_NS,
  parameter int unsigned JAM_10M_CYC  = `AFC_JAM_10M_NS / `AFC_CLK_NS
) (
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [31:0] reg_rdata_o,
  input  wire logic [13:0] rx_fifo_level_i,
  input  wire logic        tx_enable_i,
  input  wire logic        full_duplex_i,
  input  wire logic        speed_100_i,
  input  wire logic [15:0] pause_time_value_i,
  input  wire logic        frame_start_i,
  input  wire logic        addr_valid_i,
  input  wire logic        frame_multicast_i,
  input  wire logic        frame_broadcast_i,
  input  wire logic        frame_own_addr_i,
  output logic             pause_req_o,
  output logic             pause_zero_o,
  output logic      [15:0] pause_time_o,
  output logic             jam_o
);

  logic [31:0]               cfg_q;
  logic [31:0]               cfg_d;
  logic [31:0]               rdata_q;
  logic [31:0]               rdata_d;
  afc_pkg::afc_fd_state_t    state_q;
  afc_pkg::afc_fd_state_t    state_d;
  logic                      pause_req_q;
  logic                      pause_req_d;
  logic                      pause_zero_q;
  logic                      pause_zero_d;
  logic [15:0]               pause_time_q;
  logic [15:0]               pause_time_d;
  logic [13:0]               jam_cnt_q;
  logic [13:0]               jam_cnt_d;

  logic [7:0] hi_thr;
  logic [7:0] lo_thr;
  logic [3:0] dur_code;
  logic       crit_any;
  logic       crit_none;
  logic [7:0] fill_units;
  logic       hi_hit;
  logic       lo_below;
  logic       jam_hit;
  logic       crit_match;

  // Jam length in cycles; table is multiples of 5 us
  function automatic logic [13:0] jam_cycles(input logic [3:0] code, input logic fast);
    logic [7:0]  units;
    logic [31:0] cyc;
    units = 8'h00;
    unique case (code)
      4'h0: units = 8'h01;
      4'h1: units = 8'h02;
      4'h2: units = 8'h03;
      4'h3: units = 8'h05;
      default: units = 8'((code - 4'h3) * 10);
    endcase
    cyc = 32'(units) * 32'(JAM_UNIT_CYC) + (fast ? 32'h0 : 32'(JAM_10M_CYC)); // R9
    return cyc[13:0];
  endfunction

  assign hi_thr     = cfg_q[`FIFO_HIGH_THRESHOLD_MSB:`FIFO_HIGH_THRESHOLD_LSB];
  assign lo_thr     = cfg_q[`FIFO_LOW_THRESHOLD_MSB:`FIFO_LOW_THRESHOLD_LSB];
  assign dur_code   = cfg_q[`AFC_DUR_MSB:`AFC_DUR_LSB];
  assign crit_any   = cfg_q[`AFC_ANY_BIT];
  assign crit_none  = cfg_q[`AFC_MULT_BIT:`AFC_ANY_BIT] == 4'h0; // R17
  // Level in 64-byte units, so compare against raw thresholds
  assign fill_units = rx_fifo_level_i[13:6];
  assign hi_hit     = fill_units >= hi_thr; // R2
  assign lo_below   = fill_units < lo_thr; // R5

  // Criteria only matter once the destination is decoded
  assign crit_match = (cfg_q[`AFC_MULT_BIT] && frame_multicast_i) // R10
                   || (cfg_q[`AFC_BRD_BIT] && frame_broadcast_i) // R11
                   || (cfg_q[`AFC_ADD_BIT] && frame_own_addr_i); // R12

  always_comb begin
    jam_hit = 1'b0;
    if (tx_enable_i && !full_duplex_i && hi_hit) begin // R1 R4 R8
      if (crit_any) begin
        jam_hit = frame_start_i; // R14 R16
      end else begin
        jam_hit = addr_valid_i && crit_match; // R10 R11 R12
      end
    end
  end

  always_comb begin
    cfg_d   = cfg_q;
    rdata_d = 32'h0000_0000;
    if (reg_wr_i && reg_addr_i == `AUTO_FLOW_CONTROL_CONFIG_OFFSET) begin
      cfg_d = reg_wdata_i & `AUTO_FLOW_CONTROL_CONFIG_WMASK;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `AUTO_FLOW_CONTROL_CONFIG_OFFSET:    rdata_d = cfg_q;
        `AFC_STATUS_OFFSET: rdata_d = {14'h0000, jam_cnt_q, 1'b0, jam_o,
                                       state_q == afc_pkg::FC_PAUSED, hi_hit};
        default:            rdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    state_d      = state_q;
    pause_req_d  = 1'b0;
    pause_zero_d = pause_zero_q;
    pause_time_d = pause_time_q;
    unique case (state_q)
      afc_pkg::FC_IDLE: begin
        // Single request; MAC queues it for its next window
        if (tx_enable_i && full_duplex_i && crit_any && hi_hit) begin // R1 R3 R13 R15
          state_d      = afc_pkg::FC_PAUSED;
          pause_req_d  = 1'b1;
          pause_zero_d = 1'b0;
          pause_time_d = pause_time_value_i; // R3
        end
      end
      afc_pkg::FC_PAUSED: begin
        // Disabling drops the pending resume rather than sending it late
        if (!crit_any || !full_duplex_i) begin // R6 R17
          state_d = afc_pkg::FC_IDLE;
        end else if (tx_enable_i && lo_below) begin // R1 R5 R6
          state_d      = afc_pkg::FC_IDLE;
          pause_req_d  = 1'b1;
          pause_zero_d = 1'b1;
          pause_time_d = 16'h0000;
        end
      end
    endcase
  end

  always_comb begin
    jam_cnt_d = jam_cnt_q;
    if (!tx_enable_i || full_duplex_i) begin // R1 R8
      jam_cnt_d = 14'h0000;
    end else if (jam_hit) begin // R4
      jam_cnt_d = jam_cycles(dur_code, speed_100_i); // R9
    end else if (jam_cnt_q != 14'h0000) begin
      // Reload wins over decrement, so close frames extend the jam
      jam_cnt_d = jam_cnt_q - 14'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cfg_q        <= `AUTO_FLOW_CONTROL_CONFIG_RESET;
      rdata_q      <= 32'h0000_0000;
      state_q      <= afc_pkg::FC_IDLE;
      pause_req_q  <= 1'b0;
      pause_zero_q <= 1'b0;
      pause_time_q <= 16'h0000;
      jam_cnt_q    <= 14'h0000;
    end else begin
      cfg_q        <= cfg_d;
      rdata_q      <= rdata_d;
      state_q      <= state_d;
      pause_req_q  <= pause_req_d;
      pause_zero_q <= pause_zero_d;
      pause_time_q <= pause_time_d;
      jam_cnt_q    <= jam_cnt_d;
    end
  end

  assign reg_rdata_o  = rdata_q;
  assign pause_req_o  = pause_req_q;
  assign pause_zero_o = pause_zero_q;
  assign pause_time_o = pause_time_q;
  assign jam_o        = jam_cnt_q != 14'h0000;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);

  sequence fd_high_s;
    state_q == afc_pkg::FC_IDLE && tx_enable_i && full_duplex_i && crit_any && hi_hit;
  endsequence

  sequence fd_resume_s;
    state_q == afc_pkg::FC_PAUSED && tx_enable_i && full_duplex_i && crit_any && lo_below;
  endsequence

  // Decode cycle of a half-duplex frame with criteria mode active
  sequence hd_decode_s;
    !full_duplex_i && tx_enable_i && !crit_any && hi_hit && addr_valid_i;
  endsequence

  pause_txoff_a: assert property (pause_req_o |-> $past(tx_enable_i)) // R1
    else $error("Pause request while transmitter was disabled");

  jam_txoff_a: assert property (!tx_enable_i |=> !jam_o) // R1
    else $error("Jam active after transmitter disabled");

  pause_high_a: assert property (fd_high_s |=> pause_req_o && !pause_zero_o
                                 && pause_time_o == $past(pause_time_value_i)) // R3
    else $error("No pause frame at high threshold");

  pause_single_a: assert property (pause_req_o && !pause_zero_o |=> !pause_req_o
                                   ##0 state_q == afc_pkg::FC_PAUSED || pause_zero_o) // R3
    else $error("Second full pause without resume");

  pause_resume_a: assert property (fd_resume_s |=> pause_req_o && pause_zero_o
                                   && pause_time_o == 16'h0000) // R5
    else $error("No zero-time pause below low threshold");

  resume_after_a: assert property (pause_req_o && pause_zero_o
                                   |-> $past(state_q) == afc_pkg::FC_PAUSED) // R6
    else $error("Zero pause without earlier pause");

  jam_any_a: assert property (!full_duplex_i && tx_enable_i && crit_any && hi_hit
                              && frame_start_i |=> jam_o) // R14
    else $error("No jam at preamble in any-frame mode");

  jam_mcast_a: assert property (!full_duplex_i && tx_enable_i && !crit_any && hi_hit
                                && addr_valid_i && cfg_q[`AFC_MULT_BIT] && frame_multicast_i
                                |=> jam_o) // R10
    else $error("No jam on multicast frame");

  jam_length_a: assert property ($rose(jam_o) |-> jam_cnt_q
                                 == jam_cycles($past(dur_code), $past(speed_100_i))) // R9
    else $error("Jam duration wrong");

  jam_fdx_a: assert property (full_duplex_i |=> !jam_o) // R8
    else $error("Jam in full duplex");

  no_crit_a: assert property (crit_none && !jam_o |=> !jam_o && !pause_req_o) // R17
    else $error("Action with no criteria set");

  // Checks below lean on internal state for visibility
  cfg_write_a: assert property (reg_wr_i && reg_addr_i == `AUTO_FLOW_CONTROL_CONFIG_OFFSET // R2
                                |=> cfg_q == ($past(reg_wdata_i) & `AUTO_FLOW_CONTROL_CONFIG_WMASK))
    else $error("Config write not taken");

  pause_fdx_only_a: assert property (pause_req_o // R13
                                     |-> $past(full_duplex_i) && $past(crit_any))
    else $error("Pause request outside full-duplex any-frame mode");

  zero_time_a: assert property (pause_req_o && pause_zero_o |-> pause_time_o == 16'h0000) // R5
    else $error("Resume pause carries nonzero time");

  resume_low_a: assert property (pause_req_o && pause_zero_o |-> $past(lo_below)) // R5
    else $error("Resume pause while fill not below low");

  jam_bcast_a: assert property (hd_decode_s ##0 (cfg_q[`AFC_BRD_BIT] && frame_broadcast_i) // R11
                                |=> jam_o)
    else $error("No jam on broadcast frame");

  jam_own_a: assert property (hd_decode_s ##0 (cfg_q[`AFC_ADD_BIT] && frame_own_addr_i) // R12
                              |=> jam_o)
    else $error("No jam on own-address frame");

  jam_anyonly_a: assert property (crit_any && !frame_start_i && !jam_o |=> !jam_o) // R16
    else $error("Jam from decode in any-frame mode");

  jam_low_a: assert property (!hi_hit && !jam_o |=> !jam_o) // R2
    else $error("Jam below high threshold");

  jam_count_a: assert property (jam_o && !jam_hit && tx_enable_i && !full_duplex_i // R4
                                |=> jam_cnt_q == $past(jam_cnt_q) - 14'h0001)
    else $error("Jam counter did not step down");

  time_hold_a: assert property (!pause_req_o |-> $stable(pause_time_o)) // R3
    else $error("Pause time changed without request");

endmodule // afc_flow_ctrl
`default_nettype wire

// File: hw/afc_params.svh
`ifndef AFC_PARAMS_SVH
`define AFC_PARAMS_SVH
`define AUTO_FLOW_CONTROL_CONFIG_OFFSET     8'hac
`define AFC_STATUS_OFFSET  8'hc0
`define AUTO_FLOW_CONTROL_CONFIG_RESET      32'h0000_0000
`define AUTO_FLOW_CONTROL_CONFIG_WMASK      32'h00ff_ffff
`define FIFO_HIGH_THRESHOLD_MSB         23
`define FIFO_HIGH_THRESHOLD_LSB         16
`define FIFO_LOW_THRESHOLD_MSB         15
`define FIFO_LOW_THRESHOLD_LSB         8
`define AFC_DUR_MSB        7
`define AFC_DUR_LSB        4
`define AFC_MULT_BIT       3
`define AFC_BRD_BIT        2
`define AFC_ADD_BIT        1
`define AFC_ANY_BIT        0
`define AFC_CLK_NS         40
`define AFC_JAM_UNIT_NS    5000
`define AFC_JAM_10M_NS     2200
`endif

// File: hw/afc_pkg.sv
package afc_pkg;
  typedef enum logic [0:0] {
    FC_IDLE,
    FC_PAUSED
  } afc_fd_state_t;
endpackage

// File: verif/afc_station.sv
`timescale 1ns/1ps
`default_nettype none
module afc_station (
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [1:0] kind_i,
  input  wire logic       pause_req_i,
  output logic            frame_start_o,
  output logic            addr_valid_o,
  output logic [2:0]      kind_flags_o,
  output int              pauses_o
);
  logic [1:0] kind_q  = 2'h0;
  logic       fs_q    = 1'b0;
  logic       av_q    = 1'b0;
  logic [2:0] flags_q = 3'h0;
  int         cnt_q   = 0;
  // Preamble precedes address decode, as on a real wire
  always @(posedge clk_i) begin
    fs_q <= go_i;
    av_q <= fs_q;
    kind_q <= go_i ? kind_i : kind_q;
    // Flags only mean something at decode, so they toggle otherwise
    flags_q <= fs_q ? {kind_q == 2'h1, kind_q == 2'h2, kind_q == 2'h3} : ~flags_q;
    if (pause_req_i) cnt_q <= cnt_q + 1;
  end
  assign frame_start_o = fs_q;
  assign addr_valid_o  = av_q;
  assign kind_flags_o  = flags_q;
  assign pauses_o      = cnt_q;
endmodule // afc_station
`default_nettype wire

// File: verif/afc_flow_ctrl_tb.sv
`include "afc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module afc_flow_ctrl_tb;
  localparam int JU = 2;
  localparam int J10 = 1;
  logic        clk, rst, wr, rd, txen, fd, s100, go, fs, av, preq, pzero, jam;
  logic [7:0]  addr, hi, lo;
  logic [31:0] wdata, rdata, lfsr, v;
  logic [13:0] fill;
  logic [15:0] ptv, ptime;
  logic [2:0]  kf;
  logic [1:0]  kind;
  int          errors, n_checks, pauses, n;
  afc_flow_ctrl #(.JAM_UNIT_CYC(JU), .JAM_10M_CYC(J10)) afc_flow_ctrl_inst (
    .sys_clk_i(clk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .rx_fifo_level_i(fill),
    .tx_enable_i(txen), .full_duplex_i(fd), .speed_100_i(s100),
    .pause_time_value_i(ptv), .frame_start_i(fs), .addr_valid_i(av),
    .frame_multicast_i(kf[2]), .frame_broadcast_i(kf[1]), .frame_own_addr_i(kf[0]),
    .pause_req_o(preq), .pause_zero_o(pzero), .pause_time_o(ptime), .jam_o(jam));
  afc_station afc_station_inst (.clk_i(clk), .go_i(go), .kind_i(kind), .pause_req_i(preq),
    .frame_start_o(fs), .addr_valid_o(av), .kind_flags_o(kf), .pauses_o(pauses));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  function automatic int jam_len(logic [3:0] c, logic s);
    int u;
    u = (c < 4'h3) ? int'(c) + 1 : (c == 4'h3) ? 5 : (int'(c) - 3) * 10;
    return u * JU + (s ? 0 : J10);
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr32(logic [7:0] a, logic [31:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd32(logic [7:0] a, logic [31:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask
  task automatic cnt_pause(output int c);
    c = 0;
    repeat (20) begin
      @(posedge clk);
      #1 c += (preq === 1'b1);
    end
  endtask
  task automatic cnt_jam(logic [1:0] k, output int c);
    kind <= k; go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    c = 0;
    repeat (300) begin
      @(posedge clk);
      #1 c += (jam === 1'b1);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #(40 * 40000) errors++;
    end_sim();
  end
  initial begin
    lfsr = 32'h1dd9; errors = 0; n_checks = 0; rst = 1'b1; wr = 1'b0; rd = 1'b0;
    txen = 1'b0; fd = 1'b1; s100 = 1'b1; go = 1'b0; kind = 2'h0; addr = 8'h0;
    wdata = 32'h0; fill = 14'h0; ptv = 16'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, `AUTO_FLOW_CONTROL_CONFIG_RESET);
    v = rnd();
    wr32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, v);
    rd32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, v & `AUTO_FLOW_CONTROL_CONFIG_WMASK);
    rd32(8'h10, 32'h0);
    $display("test registers done");
    hi = 8'(8'h10 + rnd() % 64); lo = 8'(hi - 8'h1 - rnd() % 8); ptv <= 16'(rnd());
    wr32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, {8'h0, hi, lo, 8'h01});
    fill <= {hi, 6'h3f};
    cnt_pause(n); chk("pause tx off", n, 0);
    txen <= 1'b1; fill <= {hi - 8'h1, 6'h3f};
    cnt_pause(n); chk("pause below hi", n, 0);
    fill <= {hi, 6'h00};
    cnt_pause(n); chk("pause count", n, 1);
    chk("pause time", ptime, ptv); chk("pause zero", pzero, 0);
    rd32(`AFC_STATUS_OFFSET, 32'h0000_0003);
    fill <= {lo, 6'h00};
    cnt_pause(n); chk("no resume at lo", n, 0);
    fill <= {lo - 8'h1, 6'h3f};
    cnt_pause(n); chk("resume count", n, 1);
    chk("resume time", ptime, 0); chk("resume zero", pzero, 1);
    cnt_pause(n); chk("single resume", n, 0);
    wr32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, {8'h0, hi, lo, 8'h00}); fill <= {hi, 6'h0};
    cnt_pause(n); chk("no criteria", n, 0);
    chk("station pauses", pauses, 2);
    cnt_jam(2'h0, n); chk("no jam full duplex", n, 0);
    $display("test pause done");
    fd <= 1'b0;
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 16; c++) begin
        wr32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, {8'h0, hi, lo, 4'(c), 3'(rnd()), 1'b1}); s100 <= s[0];
        cnt_jam(2'(c), n); chk("jam length", n, jam_len(4'(c), s[0]));
      end
    end
    for (int b = 1; b < 5; b++) begin
      for (int k = 0; k < 4; k++) begin
        wr32(`AUTO_FLOW_CONTROL_CONFIG_OFFSET, {8'h0, hi, lo, 4'h0, 4'(1 << (b % 4))});
        cnt_jam(2'(k), n);
        chk("jam criteria", n, (b == 4 || (k != 0 && b == 4 - k)) ? jam_len(4'h0, 1'b1) : 0);
      end
    end
    fill <= {hi - 8'h1, 6'h3f};
    cnt_jam(2'h0, n); chk("jam below hi", n, 0);
    fill <= {hi, 6'h0}; txen <= 1'b0;
    cnt_jam(2'h3, n); chk("jam tx off", n, 0);
    $display("test jam done");
    end_sim();
  end
endmodule // afc_flow_ctrl_tb
`default_nettype wire
